//--- dv/serial_peer_model.sv
// remote serial transceiver model: sends and takes frames on the line
`timescale 1ns/1ps
module serial_peer_model (
	input  wire logic ref_clk,
	input  wire logic line_in,
	output logic      line_out
);
	int bit_clks;

	// bit time must match the divisor the bench programs; line idles high
	initial begin
		bit_clks = 32;
		line_out = 1'h1;
	end

	// start, data lsb first, stop; call right after a rising edge
	task automatic send_char(input logic [8:0] c, input int nbits);
		line_out <= 1'h0;
		repeat (bit_clks) @(posedge ref_clk);
		for (int i = 0; i < nbits; i++) begin
			line_out <= c[i];
			repeat (bit_clks) @(posedge ref_clk);
		end
		line_out <= 1'h1;
		repeat (bit_clks) @(posedge ref_clk);
	endtask : send_char

	// bounded wait for a start bit, then each bit taken at its middle
	task automatic take_char(input int nbits, output logic [8:0] c, output logic ok);
		int n;
		n = 0;
		c = 9'h000;
		while (line_in !== 1'h0 && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (bit_clks / 2) @(posedge ref_clk);
		for (int i = 0; i < nbits; i++) begin
			repeat (bit_clks) @(posedge ref_clk);
			c[i] = line_in;
		end
		repeat (bit_clks) @(posedge ref_clk);
		ok = (n < 20000) && (line_in === 1'h1);
	endtask : take_char
endmodule : serial_peer_model

//--- dv/uart_format_loop_config_assertions.sv
// concurrent checks on the ports of the serial format and loop control block
`timescale 1ns/1ps
module uart_format_loop_config_assertions (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        cpu_wait,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        rx_pin_release,
	input wire logic        tx_pin_out,
	input wire logic        tx_pin_oe
);
	logic [7:0] ctl1_q, ctl1_d;
	logic [2:0] ctl2_q, ctl2_d;
	logic       quiet_wire;

	// shadow of the control registers, taken only at the accepting edge
	always_comb begin
		ctl1_d = ctl1_q;
		ctl2_d = ctl2_q;
		if (avs_write && !avs_waitrequest && avs_address == uart_cfg_pkg::OFS_CTRL1) begin
			ctl1_d = avs_writedata[7:0];
		end
		if (avs_write && !avs_waitrequest && avs_address == uart_cfg_pkg::OFS_CTRL2) begin
			ctl2_d = avs_writedata[2:0];
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl1_q <= 8'h00;
			ctl2_q <= 3'h0;
		end else begin
			ctl1_q <= ctl1_d;
			ctl2_q <= ctl2_d;
		end
	end
	// single wire with the direction bit clear: the pin must be left to the peer
	assign quiet_wire = ctl1_q[7] && ctl1_q[5] && !ctl2_q[2];

	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence frozen_s;
		cpu_wait && ctl1_q[6] ##1 cpu_wait;
	endsequence

	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request held off more than one cycle");
	idle_bus_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest high with no request");
	ctrl_readback_a: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00
		|-> avs_readdata == {24'h000000, ctl1_q}) else $error("control one reads wrong");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h10
		|-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
	reset_outputs_a: assert property ($rose(arst_n) |-> avs_readdata == 32'h0 && tx_pin_out
		&& !tx_pin_oe && rx_pin_release) else $error("outputs not at reset level");
	pin_release_a: assert property (rx_pin_release == (ctl1_q[7] || !ctl2_q[1]))
		else $error("receive pin release wrong");
	listen_quiet_a: assert property (quiet_wire |-> !tx_pin_oe)
		else $error("shared pin driven while set to listen");
	start_drive_a: assert property ($fell(tx_pin_out) && !quiet_wire |-> tx_pin_oe)
		else $error("start bit sent with pin not driven");
	start_bit_a: assert property ($fell(tx_pin_out) |-> !tx_pin_out [*8])
		else $error("start bit shorter than eight clocks");
	wait_freeze_a: assert property (frozen_s |-> $stable(tx_pin_out))
		else $error("transmit line moved while frozen");
endmodule : uart_format_loop_config_assertions

bind uart_format_loop_config uart_format_loop_config_assertions chk (.ref_clk(ref_clk),
	.arst_n(arst_n), .cpu_wait(cpu_wait), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .rx_pin_release(rx_pin_release),
	.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe));

//--- dv/uart_format_loop_config_tb.sv
// self-checking bench for the serial format and loop control block
`timescale 1ns/1ps
module uart_format_loop_config_tb;
	logic        ref_clk, arst_n, clk_en, cpu_wait, avs_read, avs_write;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic        avs_waitrequest, rx_pin_release, tx_pin_out, tx_pin_oe;
	logic        peer_line, rx_jam_n, tx_wire, ok, moved;
	logic [8:0]  got;
	int          bad_count, samples_checked;

	// shared transmit wire: the block when it drives, else the peer
	assign tx_wire = tx_pin_oe ? tx_pin_out : peer_line;

	uart_format_loop_config DUT (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
		.cpu_wait(cpu_wait), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_pin(peer_line & rx_jam_n),
		.rx_pin_release(rx_pin_release), .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out),
		.tx_pin_oe(tx_pin_oe));
	serial_peer_model peer (.ref_clk(ref_clk), .line_in(tx_wire), .line_out(peer_line));

	initial begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// request held until the rising edge after waitrequest is seen low at a falling edge
	task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] wd);
		logic w;
		int   n;
		n = 0;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(negedge ref_clk);
			w = avs_waitrequest;
			@(posedge ref_clk);
			n++;
		end while (w !== 1'h0 && n < 100);
		rd = avs_readdata;
		avs_read  <= 1'h0;
		avs_write <= 1'h0;
		if (w !== 1'h0) begin
			bad_count++;
			results();
		end
	endtask : bus
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(a, 1'h0, 32'h0);
		check(rd, e);
	endtask : rdc
	task automatic set1(input logic [31:0] d);
		bus(uart_cfg_pkg::OFS_CTRL1, 1'h1, d);
	endtask : set1
	task automatic set2(input logic [31:0] d);
		bus(uart_cfg_pkg::OFS_CTRL2, 1'h1, d);
	endtask : set2
	// peer listens while the block is handed one character
	task automatic tx_char(input logic [31:0] d, input int nbits);
		fork
			peer.take_char(nbits, got, ok);
			bus(uart_cfg_pkg::OFS_DATA, 1'h1, d);
		join
	endtask : tx_char
	// peer sends one character; status polled until the receiver holds it
	task automatic rx_char(input logic [8:0] c);
		int n;
		n = 0;
		@(posedge ref_clk);
		peer.send_char(c, 8);
		rd = 32'h0;
		while (rd[uart_cfg_pkg::RXFULL_BIT] !== 1'h1 && n < 2000) begin
			bus(uart_cfg_pkg::OFS_STAT, 1'h0, 32'h0);
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			results();
		end
	endtask : rx_char

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		logic [7:0] cfg [6] = '{8'h10, 8'h02, 8'h03, 8'h13, 8'h12, 8'h0C};
		logic [8:0] din [6] = '{9'h1C3, 9'h007, 9'h087, 9'h055, 9'h155, 9'h05A};
		logic [8:0] dex [6] = '{9'h1C3, 9'h087, 9'h007, 9'h155, 9'h055, 9'h05A};
		rdc(uart_cfg_pkg::OFS_CTRL1, 32'h0);
		bus(5'h14, 1'h1, 32'hFF);
		rdc(5'h14, 32'h0);
		for (int i = 0; i < 8; i++) begin
			set1(32'h1 << i);
			rdc(uart_cfg_pkg::OFS_CTRL1, 32'h1 << i);
		end
		set1(32'hFFFFFFFF);
		rdc(uart_cfg_pkg::OFS_CTRL1, 32'hFF);
		bus(uart_cfg_pkg::OFS_BAUD, 1'h1, 32'h2);
		set2(32'h3);
		// every length and parity setting, wake and idle bits leave the frame alone
		for (int i = 0; i < 6; i++) begin
			set1({24'h0, cfg[i]});
			tx_char({23'h0, din[i]}, cfg[i][4] ? 9 : 8);
			check(got, dex[i]);
			check(ok, 1'h1);
		end
		set1(32'h2); // even parity, eight bits, for the receive checks
		rx_char(9'h007);
		check(rd[uart_cfg_pkg::PERR_BIT], 1'h1);
		rdc(uart_cfg_pkg::OFS_DATA, 32'h7);
		bus(uart_cfg_pkg::OFS_STAT, 1'h1, 32'h3C);
		rx_char(9'h087);
		check(rd[uart_cfg_pkg::PERR_BIT], 1'h0);
		rdc(uart_cfg_pkg::OFS_DATA, 32'h87);
		$display("test registers and formats done");
	endtask : t_regs
	task automatic t_normal();
		set1(32'h20);
		cpu_wait <= 1'h1;
		@(negedge ref_clk);
		check(rx_pin_release, 1'h0);
		tx_char(32'hA5, 8);
		check(got, 9'h0A5);
		rx_char(9'h03C);
		rdc(uart_cfg_pkg::OFS_DATA, 32'h3C);
		// address-mark standby: a clear msb is dropped, a set msb wakes and is kept
		set1(32'h08);
		set2(32'hB);
		@(posedge ref_clk);
		peer.send_char(9'h011, 8);
		bus(uart_cfg_pkg::OFS_STAT, 1'h0, 32'h0);
		check(rd[uart_cfg_pkg::RXFULL_BIT], 1'h0);
		check(rd[uart_cfg_pkg::IDLE_BIT], 1'h1);
		rx_char(9'h0C4);
		rdc(uart_cfg_pkg::OFS_CTRL2, 32'h3);
		rdc(uart_cfg_pkg::OFS_DATA, 32'hC4);
		cpu_wait <= 1'h0;
		$display("test normal two pin done");
	endtask : t_normal
	task automatic t_loopback_select();
		set1(32'h80);
		rx_jam_n <= 1'h0;
		@(negedge ref_clk);
		check(rx_pin_release, 1'h1);
		bus(uart_cfg_pkg::OFS_DATA, 1'h1, 32'h5A);
		rx_char(9'h1FF);
		rdc(uart_cfg_pkg::OFS_DATA, 32'h5A);
		set2(32'h2);
		set1(32'hA0);
		@(negedge ref_clk);
		check(tx_pin_oe, 1'h0);
		rx_char(9'h069);
		rdc(uart_cfg_pkg::OFS_DATA, 32'h69);
		set2(32'h7);
		@(negedge ref_clk);
		check(tx_pin_oe, 1'h1);
		tx_char(32'h33, 8);
		check(got, 9'h033);
		rdc(uart_cfg_pkg::OFS_DATA, 32'h33);
		rx_jam_n <= 1'h1;
		$display("test loop and single wire done");
	endtask : t_loopback_select
	task automatic t_freeze();
		set2(32'h3);
		set1(32'h40);
		cpu_wait <= 1'h1;
		bus(uart_cfg_pkg::OFS_DATA, 1'h1, 32'h81);
		moved = 1'h0;
		repeat (200) begin
			@(negedge ref_clk);
			moved = moved | (tx_pin_out !== 1'h1);
		end
		check(moved, 1'h0);
		@(posedge ref_clk);
		fork
			peer.take_char(8, got, ok);
			cpu_wait <= 1'h0;
		join
		check(got, 9'h081);
		check(ok, 1'h1);
		$display("test wait freeze done");
	endtask : t_freeze

	initial begin
		arst_n = 1'h0;
		clk_en = 1'h1;
		cpu_wait = 1'h0;
		avs_address = 5'h00;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0;
		rx_jam_n = 1'h1;
		bad_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'h1;
		t_regs();
		t_normal();
		t_loopback_select();
		t_freeze();
		results();
	end
endmodule : uart_format_loop_config_tb

//--- src/uart_cfg_pkg.sv
// constants, field positions and shared helpers of the serial control block
package uart_cfg_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [4:0]  OFS_CTRL1 = 5'h00;
	localparam logic [4:0]  OFS_CTRL2 = 5'h04;
	localparam logic [4:0]  OFS_BAUD  = 5'h08;
	localparam logic [4:0]  OFS_DATA  = 5'h0C;
	localparam logic [4:0]  OFS_STAT  = 5'h10;

	// control one fields
	localparam int LOOP_BIT = 7;
	localparam int WAIT_BIT = 6;
	localparam int SRC_BIT  = 5;
	localparam int LEN_BIT  = 4;
	localparam int WAKE_BIT = 3;
	localparam int ITYP_BIT = 2;
	localparam int PEN_BIT  = 1;
	localparam int PTY_BIT  = 0;

	// control two fields
	localparam int TXEN_BIT = 0;
	localparam int RXEN_BIT = 1;
	localparam int DIR_BIT  = 2;
	localparam int STBY_BIT = 3;

	// status fields
	localparam int TXFREE_BIT = 0;
	localparam int RXFULL_BIT = 1;
	localparam int PERR_BIT   = 2;
	localparam int FERR_BIT   = 3;
	localparam int OVR_BIT    = 4;
	localparam int IDLE_BIT   = 5;
	localparam int TXBUSY_BIT = 6;

	// ****************************************
	// reset values and counts
	// ****************************************
	localparam logic [7:0]  CTRL1_RST    = 8'h00;
	localparam logic [3:0]  CTRL2_RST    = 4'h0;
	localparam logic [12:0] BAUD_RST     = 13'h0004;
	localparam logic [3:0]  OVS_LAST     = 4'hF;
	localparam logic [3:0]  MID_SAMPLE   = 4'h7;
	localparam logic [3:0]  FRAME_BITS_8 = 4'hA;
	localparam logic [3:0]  FRAME_BITS_9 = 4'hB;
	localparam logic [3:0]  RX_BITS_8    = 4'h9;
	localparam logic [3:0]  RX_BITS_9    = 4'hA;
	localparam logic [8:0]  IDLE_TICKS_8 = 9'h0A0;
	localparam logic [8:0]  IDLE_TICKS_9 = 9'h0B0;

	// parity (xor) of the data bits below the msb, plus the msb when asked
	function automatic logic data_xor(input logic [8:0] d, input logic nine, input logic with_msb);
		logic r;
		r = nine ? ^d[7:0] : ^d[6:0];
		if (with_msb) begin
			r = r ^ (nine ? d[8] : d[7]);
		end
		return r;
	endfunction : data_xor

endpackage : uart_cfg_pkg

//--- src/uart_format_loop_config.sv
// serial transceiver with format, loop and single-wire control behind avalon-mm
`timescale 1ns/1ps
module uart_format_loop_config (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	input  wire logic        cpu_wait,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rx_pin,
	output logic             rx_pin_release,
	input  wire logic        tx_pin_in,
	output logic             tx_pin_out,
	output logic             tx_pin_oe
);
	// ****************************************
	// declarations
	// ****************************************
	logic [7:0]  ctrl1_q, ctrl1_d;
	logic [3:0]  ctrl2_q, ctrl2_d;
	logic [12:0] baud_q, baud_d;
	logic [8:0]  tx_buf_q, tx_buf_d;
	logic        tx_full_q, tx_full_d;
	logic [8:0]  rx_buf_q, rx_buf_d;
	logic        rx_full_q, rx_full_d;
	logic        perr_q, perr_d;
	logic        ferr_q, ferr_d;
	logic        ovr_q, ovr_d;
	logic        idle_q, idle_d;
	logic        ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [2:0]  rx_sync_q, rx_sync_d;
	logic [2:0]  tx_sync_q, tx_sync_d;
	logic        rx_lvl_q, rx_lvl_d;
	logic        tx_lvl_q, tx_lvl_d;
	logic [12:0] baud_cnt_q, baud_cnt_d;
	logic [3:0]  bit_sub_q, bit_sub_d;

	logic        loop_sel, src_sel, nine, pen, pty;
	logic        tx_en, rx_en, sw_dir, standby;
	logic        run, tick16, bit_tick;
	logic        req, acc, wr_acc, rd_acc;
	logic        tx_start, tx_busy, tx_serial, rx_source;
	logic        rx_valid, rx_stop_bad, rx_idle, rx_take, rx_msb;
	logic [8:0]  rx_char, tx_word;
	logic [31:0] rd_mux;

	// ****************************************
	// field decode
	// ****************************************
	assign loop_sel = ctrl1_q[uart_cfg_pkg::LOOP_BIT];
	assign src_sel  = ctrl1_q[uart_cfg_pkg::SRC_BIT];
	assign nine     = ctrl1_q[uart_cfg_pkg::LEN_BIT];
	assign pen      = ctrl1_q[uart_cfg_pkg::PEN_BIT];
	assign pty      = ctrl1_q[uart_cfg_pkg::PTY_BIT];
	assign tx_en    = ctrl2_q[uart_cfg_pkg::TXEN_BIT];
	assign rx_en    = ctrl2_q[uart_cfg_pkg::RXEN_BIT];
	assign sw_dir   = ctrl2_q[uart_cfg_pkg::DIR_BIT];
	assign standby  = ctrl2_q[uart_cfg_pkg::STBY_BIT];

	// serial logic stops in cpu wait only when asked; registers stay reachable
	assign run = clk_en & ~(cpu_wait & ctrl1_q[uart_cfg_pkg::WAIT_BIT]);

	// ****************************************
	// pin synchronisers and baud timing
	// ****************************************
	// a pin level is accepted only once the last two stages agree
	always_comb begin
		rx_sync_d  = {rx_sync_q[1:0], rx_pin};
		tx_sync_d  = {tx_sync_q[1:0], tx_pin_in};
		rx_lvl_d   = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_lvl_q;
		tx_lvl_d   = (tx_sync_q[1] == tx_sync_q[2]) ? tx_sync_q[2] : tx_lvl_q;
		baud_cnt_d = baud_cnt_q;
		bit_sub_d  = bit_sub_q;
		tick16     = 1'b0;
		bit_tick   = 1'b0;
		if (run) begin
			if (baud_q == 13'h0000) begin
				baud_cnt_d = 13'h0000; // divisor zero parks the generator
			end else if (baud_cnt_q >= baud_q - 13'h0001) begin
				baud_cnt_d = 13'h0000;
				tick16 = 1'b1;
			end else begin
				baud_cnt_d = baud_cnt_q + 13'h0001;
			end
			if (tick16) begin
				bit_sub_d = bit_sub_q + 4'h1;
				bit_tick = (bit_sub_q == uart_cfg_pkg::OVS_LAST);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sync_q  <= 3'h7;
			tx_sync_q  <= 3'h7;
			rx_lvl_q   <= 1'b1;
			tx_lvl_q   <= 1'b1;
			baud_cnt_q <= 13'h0000;
			bit_sub_q  <= 4'h0;
		end else if (clk_en) begin
			rx_sync_q  <= rx_sync_d;
			tx_sync_q  <= tx_sync_d;
			rx_lvl_q   <= rx_lvl_d;
			tx_lvl_q   <= tx_lvl_d;
			baud_cnt_q <= baud_cnt_d;
			bit_sub_q  <= bit_sub_d;
		end
	end

	// ****************************************
	// line routing
	// ****************************************
	// loop off: separate pins, source bit ignored; loop on: internal or one wire
	always_comb begin
		rx_source = rx_lvl_q;
		tx_pin_out = tx_serial;
		tx_pin_oe = tx_en | tx_busy;
		if (loop_sel) begin
			if (!src_sel) begin
				rx_source = tx_serial;
			end else begin
				tx_pin_oe = (tx_en | tx_busy) & sw_dir;
				rx_source = sw_dir ? tx_serial : tx_lvl_q;
			end
		end
	end

	// receive pin goes back to general i/o in loop modes even with receiver on
	assign rx_pin_release = loop_sel | ~rx_en;

	// ****************************************
	// transmitter and receiver
	// ****************************************
	// parity replaces the msb; the ones count then matches the selected type
	always_comb begin
		tx_word = tx_buf_q;
		if (pen) begin
			if (nine) begin
				tx_word[8] = uart_cfg_pkg::data_xor(tx_buf_q, 1'b1, 1'b0) ^ pty;
			end else begin
				tx_word[7] = uart_cfg_pkg::data_xor(tx_buf_q, 1'b0, 1'b0) ^ pty;
				tx_word[8] = 1'b0;
			end
		end
	end

	// the shifter starts on a bit boundary so every bit lasts sixteen ticks
	assign tx_start = tx_full_q & tx_en & ~tx_busy & bit_tick;

	uart_tx_frame u_tx (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.run     (run),
		.bit_tick(bit_tick),
		.start   (tx_start),
		.data    (tx_word),
		.nine    (nine),
		.busy    (tx_busy),
		.serial  (tx_serial)
	);

	uart_rx_frame u_rx (
		.ref_clk        (ref_clk),
		.arst_n         (arst_n),
		.run            (run),
		.tick16         (tick16),
		.rx_in          (rx_source),
		.nine           (nine),
		.idle_after_stop(ctrl1_q[uart_cfg_pkg::ITYP_BIT]),
		.char_valid     (rx_valid),
		.char_data      (rx_char),
		.stop_bad       (rx_stop_bad),
		.idle_pulse     (rx_idle)
	);

	// standby drops characters unless an address mark wakes the receiver
	assign rx_msb  = nine ? rx_char[8] : rx_char[7];
	assign rx_take = run & rx_valid & rx_en
		& (~standby | (ctrl1_q[uart_cfg_pkg::WAKE_BIT] & rx_msb));

	// ****************************************
	// avalon-mm slave
	// ****************************************
	// one wait cycle: readdata is registered before waitrequest drops
	assign req = avs_read | avs_write;
	assign acc = req & ack_q;
	assign wr_acc = acc & avs_write;
	assign rd_acc = acc & avs_read;
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = rdata_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_address)
			uart_cfg_pkg::OFS_CTRL1: rd_mux[7:0] = ctrl1_q;
			uart_cfg_pkg::OFS_CTRL2: rd_mux[3:0] = ctrl2_q;
			uart_cfg_pkg::OFS_BAUD:  rd_mux[12:0] = baud_q;
			uart_cfg_pkg::OFS_DATA:  rd_mux[8:0] = rx_buf_q;
			uart_cfg_pkg::OFS_STAT: begin
				rd_mux[uart_cfg_pkg::TXFREE_BIT] = ~tx_full_q;
				rd_mux[uart_cfg_pkg::RXFULL_BIT] = rx_full_q;
				rd_mux[uart_cfg_pkg::PERR_BIT]   = perr_q;
				rd_mux[uart_cfg_pkg::FERR_BIT]   = ferr_q;
				rd_mux[uart_cfg_pkg::OVR_BIT]    = ovr_q;
				rd_mux[uart_cfg_pkg::IDLE_BIT]   = idle_q;
				rd_mux[uart_cfg_pkg::TXBUSY_BIT] = tx_busy;
			end
			default: rd_mux = 32'h0000_0000; // unmapped reads as zero
		endcase
	end

	// ****************************************
	// register file and flags
	// ****************************************
	// hardware clears happen first so a new event or a register write wins; a data write in a tx_start cycle is still dropped
	always_comb begin
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		baud_d = baud_q;
		tx_buf_d = tx_buf_q;
		tx_full_d = tx_full_q;
		rx_buf_d = rx_buf_q;
		rx_full_d = rx_full_q;
		perr_d = perr_q;
		ferr_d = ferr_q;
		ovr_d = ovr_q;
		idle_d = idle_q;
		ack_d = req & ~ack_q;
		rdata_d = (req & ~ack_q) ? rd_mux : rdata_q;
		if (tx_start) begin
			tx_full_d = 1'b0;
		end
		if (rd_acc && avs_address == uart_cfg_pkg::OFS_DATA) begin
			rx_full_d = 1'b0;
		end
		if (run && rx_idle && standby && !ctrl1_q[uart_cfg_pkg::WAKE_BIT]) begin
			ctrl2_d[uart_cfg_pkg::STBY_BIT] = 1'b0;
		end
		if (rx_take && standby) begin
			ctrl2_d[uart_cfg_pkg::STBY_BIT] = 1'b0;
		end
		if (wr_acc) begin
			unique case (avs_address)
				uart_cfg_pkg::OFS_CTRL1: ctrl1_d = avs_writedata[7:0];
				uart_cfg_pkg::OFS_CTRL2: ctrl2_d = avs_writedata[3:0];
				uart_cfg_pkg::OFS_BAUD:  baud_d = avs_writedata[12:0];
				uart_cfg_pkg::OFS_DATA: begin
					if (!tx_full_q) begin // a full holding register drops the write
						tx_buf_d = avs_writedata[8:0];
						tx_full_d = 1'b1;
					end
				end
				uart_cfg_pkg::OFS_STAT: begin
					perr_d = perr_q & ~avs_writedata[uart_cfg_pkg::PERR_BIT];
					ferr_d = ferr_q & ~avs_writedata[uart_cfg_pkg::FERR_BIT];
					ovr_d  = ovr_q & ~avs_writedata[uart_cfg_pkg::OVR_BIT];
					idle_d = idle_q & ~avs_writedata[uart_cfg_pkg::IDLE_BIT];
				end
				default: ;
			endcase
		end
		if (rx_take) begin
			if (rx_full_d) begin
				ovr_d = 1'b1; // unread character is kept, new one lost
			end else begin
				rx_buf_d = rx_char;
				rx_full_d = 1'b1;
			end
			if (pen && (uart_cfg_pkg::data_xor(rx_char, nine, 1'b1) != pty)) begin
				perr_d = 1'b1;
			end
			if (rx_stop_bad) begin
				ferr_d = 1'b1;
			end
		end
		if (run && rx_idle && rx_en) begin
			idle_d = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl1_q <= uart_cfg_pkg::CTRL1_RST;
			ctrl2_q <= uart_cfg_pkg::CTRL2_RST;
			baud_q <= uart_cfg_pkg::BAUD_RST;
			tx_buf_q <= 9'h000;
			tx_full_q <= 1'b0;
			rx_buf_q <= 9'h000;
			rx_full_q <= 1'b0;
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
			ovr_q <= 1'b0;
			idle_q <= 1'b0;
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			baud_q <= baud_d;
			tx_buf_q <= tx_buf_d;
			tx_full_q <= tx_full_d;
			rx_buf_q <= rx_buf_d;
			rx_full_q <= rx_full_d;
			perr_q <= perr_d;
			ferr_q <= ferr_d;
			ovr_q <= ovr_d;
			idle_q <= idle_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end
endmodule : uart_format_loop_config

//--- src/uart_rx_frame.sv
// receive shifter with mid-bit sampling and idle-line detection
`timescale 1ns/1ps
module uart_rx_frame (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic       tick16,
	input  wire logic       rx_in,
	input  wire logic       nine,
	input  wire logic       idle_after_stop,
	output logic            char_valid,
	output logic [8:0]      char_data,
	output logic            stop_bad,
	output logic            idle_pulse
);
	typedef enum logic {RX_WAIT, RX_RUN} rx_state_t;

	rx_state_t  st_q, st_d;
	logic [3:0] sub_q, sub_d;
	logic [3:0] bitn_q, bitn_d;
	logic [9:0] sh_q, sh_d;
	logic [8:0] idle_q, idle_d;
	logic       idle_done_q, idle_done_d;
	logic       last;

	// frame capture; sampling lands mid bit, sixteen ticks apart
	always_comb begin
		st_d = st_q;
		sub_d = sub_q;
		bitn_d = bitn_q;
		sh_d = sh_q;
		char_valid = 1'b0;
		last = (bitn_q == ((nine ? uart_cfg_pkg::RX_BITS_9 : uart_cfg_pkg::RX_BITS_8) - 4'h1));
		unique case (st_q)
			RX_WAIT: begin
				if (tick16) begin
					sub_d = rx_in ? 4'h0 : sub_q + 4'h1;
					if (!rx_in && sub_q == uart_cfg_pkg::MID_SAMPLE) begin
						st_d = RX_RUN;
						sub_d = 4'h0;
						bitn_d = 4'h0;
					end
				end
			end
			RX_RUN: begin
				if (tick16) begin
					sub_d = sub_q + 4'h1;
					if (sub_q == uart_cfg_pkg::OVS_LAST) begin
						sh_d = {rx_in, sh_q[9:1]};
						bitn_d = bitn_q + 4'h1;
						if (last) begin
							char_valid = 1'b1;
							st_d = RX_WAIT;
							sub_d = 4'h0;
						end
					end
				end
			end
		endcase
		char_data = nine ? sh_d[8:0] : {1'b0, sh_d[8:1]};
		stop_bad = ~sh_d[9];
	end

	// idle count: high ticks, sixteen per bit time; type one holds it clear until after stop
	always_comb begin
		idle_d = idle_q;
		idle_done_d = idle_done_q;
		idle_pulse = 1'b0;
		if (!rx_in || (idle_after_stop && st_q == RX_RUN)) begin
			idle_d = 9'h000;
			idle_done_d = rx_in & idle_done_q;
		end else if (tick16 && !idle_done_q) begin
			idle_d = idle_q + 9'h001;
			if (idle_d == (nine ? uart_cfg_pkg::IDLE_TICKS_9 : uart_cfg_pkg::IDLE_TICKS_8)) begin
				idle_pulse = 1'b1;
				idle_done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= RX_WAIT;
			sub_q <= 4'h0;
			bitn_q <= 4'h0;
			sh_q <= 10'h000;
			idle_q <= 9'h000;
			idle_done_q <= 1'b0;
		end else if (run) begin
			st_q <= st_d;
			sub_q <= sub_d;
			bitn_q <= bitn_d;
			sh_q <= sh_d;
			idle_q <= idle_d;
			idle_done_q <= idle_done_d;
		end
	end
endmodule : uart_rx_frame

//--- src/uart_tx_frame.sv
// transmit shifter: start bit, 8 or 9 data bits lsb first, stop bit
`timescale 1ns/1ps
module uart_tx_frame (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic       bit_tick,
	input  wire logic       start,
	input  wire logic [8:0] data,
	input  wire logic       nine,
	output logic            busy,
	output logic            serial
);
	typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

	tx_state_t   st_q, st_d;
	logic [10:0] sh_q, sh_d;
	logic [3:0]  cnt_q, cnt_d;

	// load a whole frame, then shift one bit per bit time
	always_comb begin
		st_d  = st_q;
		sh_d  = sh_q;
		cnt_d = cnt_q;
		unique case (st_q)
			TX_IDLE: begin
				if (start) begin
					sh_d  = nine ? {1'b1, data, 1'b0} : {2'b11, data[7:0], 1'b0};
					cnt_d = nine ? uart_cfg_pkg::FRAME_BITS_9 : uart_cfg_pkg::FRAME_BITS_8;
					st_d  = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (bit_tick) begin
					sh_d  = {1'b1, sh_q[10:1]};
					cnt_d = cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						st_d = TX_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q  <= TX_IDLE;
			sh_q  <= 11'h7FF;
			cnt_q <= 4'h0;
		end else if (run) begin
			st_q  <= st_d;
			sh_q  <= sh_d;
			cnt_q <= cnt_d;
		end
	end

	assign busy   = (st_q == TX_SHIFT);
	assign serial = (st_q == TX_SHIFT) ? sh_q[0] : 1'b1; // line idles high
endmodule : uart_tx_frame
